// [logic/isam_pkg.sv]
// package: constants and types for the input allocation mux
package isam_pkg;
	localparam int NUM_TERM    = 6;
	localparam int NUM_FUNC    = 9;
	localparam int SYNC_STAGES = 2;
	localparam logic [3:0] SEL_SUPPLY     = 4'h0;
	localparam logic [3:0] SEL_TERM_LAST  = 4'h6;
	localparam logic [3:0] SEL_ALWAYS_ON  = 4'h7;
	localparam logic [3:0] SEL_ALWAYS_OFF = 4'h8;
	localparam logic [3:0] SEL_INV_BASE   = 4'h9;
	localparam logic [3:0] SEL_INV_OFFSET = 4'h9;
	// probe latches: terminals 10..12 are selector 4..6
	localparam logic [3:0] SEL_PROBE_FIRST = 4'h4;
	// digit positions within a 16-bit parameter
	localparam int DIG_0 = 0;
	localparam int DIG_1 = 4;
	localparam int DIG_2 = 8;
	localparam int DIG_3 = 12;
	// function index
	localparam int F_FOT   = 0;
	localparam int F_ROT   = 1;
	localparam int F_FTL   = 2;
	localparam int F_RTL   = 3;
	localparam int F_PRB1  = 4;
	localparam int F_PRB2  = 5;
	localparam int F_HOME  = 6;
	localparam int F_DBA   = 7;
	localparam int F_FORCED_STOP  = 8;
	// active-low-named functions (/ prefix)
	localparam logic [8:0] ACT_LOW_MASK = 9'h0fc;
	// edge-processed functions (probe latches)
	localparam logic [8:0] EDGE_MASK    = 9'h030;
	localparam logic [8:0] FUNC_RST     = 9'h000;
	localparam logic [5:0] TERM_RST     = 6'h00;

	typedef struct packed {
		logic [15:0] alloc_a;
		logic [15:0] alloc_b;
		logic [15:0] alloc_c;
		logic [15:0] dyn_brake;
		logic [15:0] stop;
	} isam_cfg_s;

	typedef struct packed {
		logic forced_stop;
		logic dyn_brake_answer;
		logic home_switch;
		logic probe_latch_2;
		logic probe_latch_1;
		logic reverse_ext_torque_limit;
		logic forward_ext_torque_limit;
		logic reverse_overtravel;
		logic forward_overtravel;
	} isam_func_s;
endpackage : isam_pkg

// [logic/isam_sync.sv]
// two-stage synchroniser bank for connector contacts
`timescale 1ns/10ps
module isam_sync #(
	parameter int WIDTH  = 6,
	parameter int STAGES = 2
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_b,
	// contacts
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	typedef struct packed {
		logic [STAGES-1:0][WIDTH-1:0] stg;
	} isam_sync_st_s;

	isam_sync_st_s st_r;
	isam_sync_st_s st_nxt;

	if (STAGES < 2) begin : g_bad_stages
		$error("isam_sync needs two stages");
	end
	if (WIDTH < 1) begin : g_bad_width
		$error("isam_sync needs at least one contact");
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.stg[0] = d;
		for (int i = 1; i < STAGES; i++) begin
			st_nxt.stg[i] = st_r.stg[i-1];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.stg[STAGES-1];
endmodule : isam_sync

// [logic/isam_route.sv]
// one function's terminal and polarity selection
`timescale 1ns/10ps
module isam_route #(
	parameter logic ACT_LOW = 1'b0,
	parameter logic EDGE    = 1'b0,
	parameter logic PROBE   = 1'b0
) (
	// selector
	input  wire logic [3:0] sel,
	// synchronised closed state per terminal, bit 0 = terminal 7
	input  wire logic [5:0] closed,
	// result
	output logic            active
);
	logic [3:0] idx;
	logic       inv;
	logic       c;

	always_comb begin
		inv = sel >= isam_pkg::SEL_INV_BASE;
		idx = inv ? 4'(sel - isam_pkg::SEL_INV_OFFSET) : sel;
		c = 1'b0;
		// selector 0 / 9: supply terminal, contact always closed
		if (idx == isam_pkg::SEL_SUPPLY) begin
			c = 1'b1;
		end else if (idx <= isam_pkg::SEL_TERM_LAST) begin
			c = closed[3'(idx - 4'h1)];
		end
		active = (ACT_LOW ^ inv) ? c : ~c;
		if (PROBE && (idx < isam_pkg::SEL_PROBE_FIRST)) begin
			active = 1'b0;
		end
		if (sel == isam_pkg::SEL_ALWAYS_ON) begin
			active = ~EDGE;
		end else if (sel == isam_pkg::SEL_ALWAYS_OFF) begin
			active = 1'b0;
		end
	end
endmodule : isam_route

// [logic/isam_top.sv]
// input signal allocation mux: connector terminals to drive functions
`timescale 1ns/10ps
// Operation
// - selector 1..6 terminals 7..12, 0 supply
// - slash functions active on closed contact
// - plain functions active on open contact
// - selectors 9..F same terminals, inverted polarity
// - selector 7 always active, edge ones inactive
// - selector 8 always inactive
// - one terminal may feed several functions, each read on its own
// - probe latches only on terminals 10..12
// - overtravel selectors in params a and b
// - torque limit selectors in param b
// - home, probes, brake answer, stop digits
module isam_top (
	// clock and reset
	input  wire logic                    CLK,
	input  wire logic                    RST_B,
	// connector contacts, bit 0 = terminal 7, 1 = closed
	input  wire logic [5:0]              TERM_CLOSED,
	// allocation parameters
	input  wire isam_pkg::isam_cfg_s     CFG,
	// drive functions, 1 = asserted
	output isam_pkg::isam_func_s         FUNC
);
	typedef struct packed {
		logic [8:0] func;
	} isam_st_s;

	isam_st_s   st_r;
	isam_st_s   st_nxt;
	logic [5:0] term_sync;
	logic [8:0][3:0] sel;
	logic [8:0] act;

	// routing cells are built for six terminals and nine functions
	if (isam_pkg::NUM_TERM != 6) begin : g_bad_term
		$error("isam_top serves six terminals only");
	end
	if (isam_pkg::NUM_FUNC != 9) begin : g_bad_func
		$error("isam_top serves nine functions only");
	end
	if (isam_pkg::SYNC_STAGES < 2) begin : g_bad_sync
		$error("isam_top needs two synchroniser stages");
	end

	isam_sync #(
		.WIDTH  (isam_pkg::NUM_TERM),
		.STAGES (isam_pkg::SYNC_STAGES)
	) u_sync (
		.clk   (CLK),
		.rst_b (RST_B),
		.d     (TERM_CLOSED),
		.q     (term_sync)
	);

	function automatic logic [3:0] digit(input logic [15:0] p,
		input int pos);
		digit = p[pos +: 4];
	endfunction : digit

	always_comb begin
		sel = '0;
		sel[isam_pkg::F_FOT]  = digit(CFG.alloc_a, isam_pkg::DIG_3);
		sel[isam_pkg::F_ROT]  = digit(CFG.alloc_b, isam_pkg::DIG_0);
		sel[isam_pkg::F_FTL]  = digit(CFG.alloc_b, isam_pkg::DIG_2);
		sel[isam_pkg::F_RTL]  = digit(CFG.alloc_b, isam_pkg::DIG_3);
		sel[isam_pkg::F_PRB1] = digit(CFG.alloc_c, isam_pkg::DIG_1);
		sel[isam_pkg::F_PRB2] = digit(CFG.alloc_c, isam_pkg::DIG_2);
		sel[isam_pkg::F_HOME] = digit(CFG.alloc_c, isam_pkg::DIG_0);
		sel[isam_pkg::F_DBA]  = digit(CFG.dyn_brake, isam_pkg::DIG_1);
		sel[isam_pkg::F_FORCED_STOP] = digit(CFG.stop, isam_pkg::DIG_0);
	end

	// every function reads the same synchronised terminal state
	generate
		for (genvar g = 0; g < isam_pkg::NUM_FUNC; g++) begin : g_fn
			isam_route #(
				.ACT_LOW (isam_pkg::ACT_LOW_MASK[g]),
				.EDGE    (isam_pkg::EDGE_MASK[g]),
				.PROBE   (isam_pkg::EDGE_MASK[g])
			) u_route (
				.sel    (sel[g]),
				.closed (term_sync),
				.active (act[g])
			);
		end
	endgenerate

	always_comb begin
		st_nxt = st_r;
		st_nxt.func = act;
	end

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			st_r.func <= isam_pkg::FUNC_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign FUNC = isam_pkg::isam_func_s'(st_r.func);

	a_fixed_on: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_FOT] == isam_pkg::SEL_ALWAYS_ON
		|=> FUNC.forward_overtravel)
		else $error("selector 7 did not assert function");
	a_edge_on: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_PRB1] == isam_pkg::SEL_ALWAYS_ON
		|=> !FUNC.probe_latch_1)
		else $error("edge function asserted by selector 7");
	a_fixed_off: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_HOME] == isam_pkg::SEL_ALWAYS_OFF
		|=> !FUNC.home_switch)
		else $error("selector 8 left function asserted");
	a_supply_ot: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_ROT] == isam_pkg::SEL_SUPPLY
		|=> !FUNC.reverse_overtravel)
		else $error("overtravel on supply terminal asserted");
	a_closed_tl: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_FTL] == 4'h1 && $stable(sel[isam_pkg::F_FTL])
		&& TERM_CLOSED[0] ##1 TERM_CLOSED[0] ##1 TERM_CLOSED[0]
		##0 sel[isam_pkg::F_FTL] == 4'h1
		|=> FUNC.forward_ext_torque_limit)
		else $error("slash function not active on closed contact");
	a_open_ot: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_FOT] == 4'h2 && !TERM_CLOSED[1]
		##1 !TERM_CLOSED[1] ##1 !TERM_CLOSED[1]
		##0 sel[isam_pkg::F_FOT] == 4'h2
		|=> FUNC.forward_overtravel)
		else $error("plain function not active on open contact");
	a_inv_tl: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_RTL] == 4'h9 |=> !FUNC.reverse_ext_torque_limit)
		else $error("inverted supply selection asserted");
	a_probe_low: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_PRB2] inside {4'h0, 4'h1, 4'h2, 4'h3}
		|=> !FUNC.probe_latch_2)
		else $error("probe latch took illegal terminal");
	a_sync_lag: assert property (@(posedge CLK) disable iff (!RST_B)
		$rose(term_sync[2]) |-> $past(TERM_CLOSED[2], 2))
		else $error("terminal sync lag wrong");

	// selector 8 parks every function inactive
	a_off_fot: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_FOT] == isam_pkg::SEL_ALWAYS_OFF
		|=> !FUNC.forward_overtravel)
		else $error("selector 8 left forward overtravel asserted");
	a_off_rot: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_ROT] == isam_pkg::SEL_ALWAYS_OFF
		|=> !FUNC.reverse_overtravel)
		else $error("selector 8 left reverse overtravel asserted");
	a_off_ftl: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_FTL] == isam_pkg::SEL_ALWAYS_OFF
		|=> !FUNC.forward_ext_torque_limit)
		else $error("selector 8 left forward torque limit asserted");
	a_off_rtl: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_RTL] == isam_pkg::SEL_ALWAYS_OFF
		|=> !FUNC.reverse_ext_torque_limit)
		else $error("selector 8 left reverse torque limit asserted");
	a_off_prb1: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_PRB1] == isam_pkg::SEL_ALWAYS_OFF
		|=> !FUNC.probe_latch_1)
		else $error("selector 8 left probe 1 asserted");
	a_off_prb2: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_PRB2] == isam_pkg::SEL_ALWAYS_OFF
		|=> !FUNC.probe_latch_2)
		else $error("selector 8 left probe 2 asserted");
	a_off_dba: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_DBA] == isam_pkg::SEL_ALWAYS_OFF
		|=> !FUNC.dyn_brake_answer)
		else $error("selector 8 left brake answer asserted");
	a_off_forced_stop: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_FORCED_STOP] == isam_pkg::SEL_ALWAYS_OFF
		|=> !FUNC.forced_stop)
		else $error("selector 8 left forced stop asserted");

	// selector 7 holds level functions on, edge functions off
	a_on_rot: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_ROT] == isam_pkg::SEL_ALWAYS_ON
		|=> FUNC.reverse_overtravel)
		else $error("selector 7 did not assert reverse overtravel");
	a_on_ftl: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_FTL] == isam_pkg::SEL_ALWAYS_ON
		|=> FUNC.forward_ext_torque_limit)
		else $error("selector 7 did not assert forward torque limit");
	a_on_rtl: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_RTL] == isam_pkg::SEL_ALWAYS_ON
		|=> FUNC.reverse_ext_torque_limit)
		else $error("selector 7 did not assert reverse torque limit");
	a_on_home: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_HOME] == isam_pkg::SEL_ALWAYS_ON
		|=> FUNC.home_switch)
		else $error("selector 7 did not assert home switch");
	a_on_dba: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_DBA] == isam_pkg::SEL_ALWAYS_ON
		|=> FUNC.dyn_brake_answer)
		else $error("selector 7 did not assert brake answer");
	a_on_forced_stop: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_FORCED_STOP] == isam_pkg::SEL_ALWAYS_ON
		|=> FUNC.forced_stop)
		else $error("selector 7 did not assert forced stop");
	a_edge_prb2: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_PRB2] == isam_pkg::SEL_ALWAYS_ON
		|=> !FUNC.probe_latch_2)
		else $error("edge function probe 2 asserted by selector 7");

	// supply terminal reads as a closed contact
	a_sup_fot: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_FOT] == isam_pkg::SEL_SUPPLY
		|=> !FUNC.forward_overtravel)
		else $error("forward overtravel on supply terminal asserted");
	a_sup_ftl: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_FTL] == isam_pkg::SEL_SUPPLY
		|=> FUNC.forward_ext_torque_limit)
		else $error("forward torque limit on supply terminal inactive");
	a_sup_rtl: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_RTL] == isam_pkg::SEL_SUPPLY
		|=> FUNC.reverse_ext_torque_limit)
		else $error("reverse torque limit on supply terminal inactive");
	a_sup_prb1: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_PRB1] == isam_pkg::SEL_SUPPLY
		|=> !FUNC.probe_latch_1)
		else $error("probe 1 took the supply terminal");
	a_sup_prb2: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_PRB2] == isam_pkg::SEL_SUPPLY
		|=> !FUNC.probe_latch_2)
		else $error("probe 2 took the supply terminal");
	a_sup_home: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_HOME] == isam_pkg::SEL_SUPPLY
		|=> FUNC.home_switch)
		else $error("home switch on supply terminal inactive");
	a_sup_dba: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_DBA] == isam_pkg::SEL_SUPPLY
		|=> FUNC.dyn_brake_answer)
		else $error("brake answer on supply terminal inactive");
	a_sup_forced_stop: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_FORCED_STOP] == isam_pkg::SEL_SUPPLY
		|=> !FUNC.forced_stop)
		else $error("forced stop on supply terminal asserted");

	// selector 9 is the supply terminal with inverted polarity
	a_inv_fot: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_FOT] == isam_pkg::SEL_INV_BASE
		|=> FUNC.forward_overtravel)
		else $error("inverted supply left forward overtravel inactive");
	a_inv_rot: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_ROT] == isam_pkg::SEL_INV_BASE
		|=> FUNC.reverse_overtravel)
		else $error("inverted supply left reverse overtravel inactive");
	a_inv_ftl: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_FTL] == isam_pkg::SEL_INV_BASE
		|=> !FUNC.forward_ext_torque_limit)
		else $error("inverted supply asserted forward torque limit");
	a_inv_prb1: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_PRB1] == isam_pkg::SEL_INV_BASE
		|=> !FUNC.probe_latch_1)
		else $error("probe 1 took the inverted supply terminal");
	a_inv_prb2: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_PRB2] == isam_pkg::SEL_INV_BASE
		|=> !FUNC.probe_latch_2)
		else $error("probe 2 took the inverted supply terminal");
	a_inv_home: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_HOME] == isam_pkg::SEL_INV_BASE
		|=> !FUNC.home_switch)
		else $error("inverted supply asserted home switch");
	a_inv_dba: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_DBA] == isam_pkg::SEL_INV_BASE
		|=> !FUNC.dyn_brake_answer)
		else $error("inverted supply asserted brake answer");
	a_inv_forced_stop: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_FORCED_STOP] == isam_pkg::SEL_INV_BASE
		|=> FUNC.forced_stop)
		else $error("inverted supply left forced stop inactive");

	// probe latches refuse terminals below 10 in either polarity
	a_prb1_low: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_PRB1] inside {4'h0, 4'h1, 4'h2, 4'h3}
		|=> !FUNC.probe_latch_1)
		else $error("probe latch 1 took illegal terminal");
	a_prb1_inv: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_PRB1] inside {4'h9, 4'ha, 4'hb, 4'hc}
		|=> !FUNC.probe_latch_1)
		else $error("probe latch 1 took illegal inverted terminal");
	a_prb2_inv: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_PRB2] inside {4'h9, 4'ha, 4'hb, 4'hc}
		|=> !FUNC.probe_latch_2)
		else $error("probe latch 2 took illegal inverted terminal");

	// reset clears outputs and the synchroniser
	a_rst_func: assert property (@(posedge CLK)
		!RST_B
		|=> FUNC == isam_pkg::isam_func_s'(isam_pkg::FUNC_RST))
		else $error("functions not cleared by reset");
	a_rst_sync: assert property (@(posedge CLK)
		!RST_B
		|=> term_sync == isam_pkg::TERM_RST)
		else $error("synchroniser not cleared by reset");

	// level functions of one polarity sharing one selector answer alike
	a_share_tl: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_FTL] == sel[isam_pkg::F_RTL]
		|=> FUNC.forward_ext_torque_limit
		== FUNC.reverse_ext_torque_limit)
		else $error("shared terminal split the torque limits");
	a_share_ot: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_FOT] == sel[isam_pkg::F_ROT]
		|=> FUNC.forward_overtravel
		== FUNC.reverse_overtravel)
		else $error("shared terminal split the overtravel inputs");
	a_share_stp: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_FOT] == sel[isam_pkg::F_FORCED_STOP]
		|=> FUNC.forward_overtravel
		== FUNC.forced_stop)
		else $error("shared terminal split overtravel and stop");
	a_share_hdb: assert property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_HOME] == sel[isam_pkg::F_DBA]
		|=> FUNC.home_switch
		== FUNC.dyn_brake_answer)
		else $error("shared terminal split home and brake answer");

	c_ot_open: cover property (@(posedge CLK) disable iff (!RST_B)
		FUNC.forward_overtravel && !FUNC.reverse_overtravel);
	c_shared: cover property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_FTL] == sel[isam_pkg::F_RTL]
		&& FUNC.forward_ext_torque_limit);
	c_probe: cover property (@(posedge CLK) disable iff (!RST_B)
		$rose(FUNC.probe_latch_1));
	c_inv_ot: cover property (@(posedge CLK) disable iff (!RST_B)
		sel[isam_pkg::F_FOT] >= isam_pkg::SEL_INV_BASE
		&& FUNC.forward_overtravel);
	c_probe2: cover property (@(posedge CLK) disable iff (!RST_B)
		$rose(FUNC.probe_latch_2));
endmodule : isam_top

// [bench/isam_contacts.sv]
// switch contacts wired to the connector terminals
`timescale 1ns/10ps
module isam_contacts (
	// clock
	input  wire logic       clk,
	// requested contact state, 1 = closed
	input  wire logic [5:0] want,
	// contacts as seen at the terminals
	output logic      [5:0] closed
);
	// contacts follow the requested state one edge later
	always_ff @(posedge clk) begin
		closed <= want;
	end
endmodule : isam_contacts

// [bench/isam_top_tb.sv]
// bench for the input allocation mux
`timescale 1ns/10ps
module isam_top_tb;
	logic                 CLK;
	logic                 RST_B;
	logic [5:0]           want;
	logic [5:0]           TERM_CLOSED;
	isam_pkg::isam_cfg_s  CFG;
	isam_pkg::isam_func_s FUNC;
	logic [8:0]           notes[$];
	int                   failures;
	int                   cmp_count;

	isam_contacts isam_contacts_i (.clk(CLK), .want(want),
		.closed(TERM_CLOSED));
	isam_top isam_top_i (.CLK(CLK), .RST_B(RST_B),
		.TERM_CLOSED(TERM_CLOSED), .CFG(CFG), .FUNC(FUNC));

	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end

	// selector of function f sits in s[4f+3:4f]; spare digits unused
	function automatic isam_pkg::isam_cfg_s pack_cfg(logic [35:0] s);
		isam_pkg::isam_cfg_s c;
		c.alloc_a   = {s[3:0], 12'h888};
		c.alloc_b   = {s[15:12], s[11:8], 4'h8, s[7:4]};
		c.alloc_c   = {4'h8, s[23:20], s[19:16], s[27:24]};
		c.dyn_brake = {8'h88, s[31:28], 4'h8};
		c.stop      = {12'h888, s[35:32]};
		return c;
	endfunction : pack_cfg

	function automatic logic [8:0] model(logic [35:0] s, logic [5:0] t);
		logic [8:0] r;
		logic [3:0] v;
		logic       c;
		int         b;
		r = 9'h000;
		for (int f = 0; f < 9; f++) begin
			v = s[4*f+:4];
			b = (v >= 4'h9) ? int'(v) - 9 : int'(v);
			c = (b == 0) ? 1'b1 : ((b <= 6) ? t[b-1] : 1'b0);
			if (v == 4'h7)
				r[f] = ~isam_pkg::EDGE_MASK[f];
			else if (v == 4'h8)
				r[f] = 1'b0;
			else if (isam_pkg::EDGE_MASK[f] && b < 4)
				r[f] = 1'b0;
			else
				r[f] = (isam_pkg::ACT_LOW_MASK[f] ? c : ~c) ^ (v >= 4'h9);
		end
		return r;
	endfunction : model

	task automatic check(logic [8:0] got, logic [8:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic apply(logic [35:0] s, logic [5:0] t);
		@(posedge CLK);
		CFG  <= pack_cfg(s);
		want <= t;
		repeat (5) @(posedge CLK);
		notes.push_back(model(s, t));
	endtask : apply

	task automatic wrap_up();
		$display("compares %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up

	// watcher: each note is compared once the outputs have settled
	always @(negedge CLK) begin
		if (notes.size() > 0)
			check(FUNC, notes.pop_front());
	end

	initial begin
		repeat (20000) @(posedge CLK);
		failures++;
		wrap_up();
	end

	initial begin
		logic [5:0] pats[4];
		pats = '{6'h00, 6'h3f, 6'h15, 6'h2a};
		RST_B = 1'b0;
		want  = 6'h00;
		CFG   = pack_cfg({9{4'h8}});
		failures  = 0;
		cmp_count = 0;
		void'($urandom(77883));
		repeat (16) @(posedge CLK);
		notes.push_back(isam_pkg::FUNC_RST);
		RST_B <= 1'b1;
		// every code on every function, all sharing one terminal
		for (int v = 0; v < 16; v++)
			foreach (pats[i])
				apply({9{v[3:0]}}, pats[i]);
		// one closed terminal at a time pins down the terminal order
		for (int k = 0; k < 6; k++)
			apply({9{4'(k + 1)}}, 6'h01 << k);
		// random allocations exercise the digit positions
		for (int n = 0; n < 80; n++)
			apply({4'($urandom), 32'($urandom)}, 6'($urandom));
		// overtravel kept at default polarity on one terminal, broken wire
		apply({20'h88888, 8'h88, 8'h11}, 6'h00);
		@(posedge CLK);
		RST_B <= 1'b0;
		repeat (2) @(posedge CLK);
		notes.push_back(isam_pkg::FUNC_RST);
		@(posedge CLK);
		RST_B <= 1'b1;
		apply({9{4'h1}}, 6'h01);
		for (int w = 0; w < 20 && notes.size() > 0; w++)
			@(posedge CLK);
		if (notes.size() > 0)
			failures++;
		wrap_up();
	end
endmodule : isam_top_tb
